// ---- common/port_pkg.sv ----
// Package: pin counts, register indices, field positions and reset values of the port block
package port_pkg;

    // Pin counts per port
    localparam int T_PINS = 4;
    localparam int S_PINS = 4;
    localparam int P_PINS = 6;
    localparam int L_PINS = 4;
    localparam int SYNC_W = T_PINS + S_PINS + P_PINS + L_PINS + 1;

    // Positions of each port inside the synchronised pin vector
    localparam int SYNC_T_LSB   = 0;
    localparam int SYNC_S_LSB   = 4;
    localparam int SYNC_P_LSB   = 8;
    localparam int SYNC_L_LSB   = 14;
    localparam int SYNC_DBG_BIT = 18;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_T_DATA   = 10'h240;
    localparam logic [9:0] IDX_T_INPUT  = 10'h241;
    localparam logic [9:0] IDX_T_DIR    = 10'h242;
    localparam logic [9:0] IDX_S_DATA   = 10'h248;
    localparam logic [9:0] IDX_S_DIR    = 10'h24A;
    localparam logic [9:0] IDX_P_DATA   = 10'h258;
    localparam logic [9:0] IDX_P_DIR    = 10'h25A;
    localparam logic [9:0] IDX_P_IE     = 10'h25C;
    localparam logic [9:0] IDX_P_POL    = 10'h25D;
    localparam logic [9:0] IDX_P_FLAG   = 10'h25F;
    localparam logic [9:0] IDX_L_INPUT  = 10'h278;
    localparam logic [9:0] IDX_L_IE     = 10'h27C;
    localparam logic [9:0] IDX_L_POL    = 10'h27D;
    localparam logic [9:0] IDX_L_FLAG   = 10'h27F;
    localparam logic [9:0] IDX_IRQ_CTRL = 10'h2A0;

    // Fields of the external interrupt control register
    localparam int IRQ_EN_BIT   = 0;
    localparam int IRQ_EDGE_BIT = 1;
    localparam int IRQ_FLAG_BIT = 2;

    // Pin positions with special functions
    localparam int PT_SCI_RX_BIT  = 0;
    localparam int PT_SHARED_BIT  = 1;
    localparam int PS_PHY_BIT     = 1;
    localparam int PS_SHARED_BIT  = 2;
    localparam int PS_SCI_TX_BIT  = 1;
    localparam int PS_SCI_RX_BIT  = 0;
    localparam int PP_IRQ_BIT     = 5;

    // Reset values
    localparam logic [7:0] REG_RST = 8'h00;

endpackage

// ---- rtl/pin_sync.sv ----
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_s;

    sync_s s_q;
    sync_s s_d;

    // Stage one feeds only stage two, to keep metastability out of logic
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            s_d.stage1[i] = asyncIn[i];
            s_d.stage2[i] = s_q.stage1[i];
        end
    end

    // No reset: mode pin must reach the core while reset is held
    always_ff @(posedge core_clk) begin
        s_q <= s_d;
    end

    assign syncOut = s_q.stage2;

endmodule

// ---- rtl/port_pin_mux_and_gpio.sv ----
// Port integration logic: pin ownership, GPIO registers, pin interrupts, APB slave
//
// Summary of operation
// - Each pin's output goes to the highest listed function sharing it.
// - Port T GPIO output drives the pin from its data bit.
// - Data read gives stored bit if direction is 1, else synced pin level.
// - T bit 1: routed serial zero or phy driver beats timer and GPIO.
// - T bit 0: routed serial zero beats timer and GPIO.
// - On port T an enabled timer channel beats GPIO.
// - Port T input register is read only, bits 3..0 pin levels, rest zero.
// - S bit 2: enabled periodic interrupt clock output forces output.
// - S bit 2: enabled SPI sets direction from its own configuration.
// - S bit 2: routed serial one forces the pin to input.
// - S bit 2: routed PWM channel forces the pin to output.
// - Routed conversion trigger leaves direction to the direction bit.
// - Forced direction never alters the stored direction bit.
// - Port S direction 1 means output, 0 means input.
// - S bits 1 and 0: enabled serial interface sets direction.
// - S bit 1: routed line transceiver phy forces output.
// - Port L pins are inputs only with wake interrupt, from reset on.
// - Debug pin is mode select during reset, debug wire afterwards.
// - P bit 5 gives maskable interrupt, low level or falling edge.
// - Port P GPIO has per pin wake interrupt, GPIO after reset.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
module port_pin_mux_and_gpio
    import port_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                sys_rst,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Package pins: input level, output value, output enable
    input  wire logic [T_PINS-1:0]   portTIn,
    output logic      [T_PINS-1:0]   portTOut,
    output logic      [T_PINS-1:0]   portTOe,
    input  wire logic [S_PINS-1:0]   portSIn,
    output logic      [S_PINS-1:0]   portSOut,
    output logic      [S_PINS-1:0]   portSOe,
    input  wire logic [P_PINS-1:0]   portPIn,
    output logic      [P_PINS-1:0]   portPOut,
    output logic      [P_PINS-1:0]   portPOe,
    input  wire logic [L_PINS-1:0]   portLIn,
    input  wire logic                debugWirePinIn,
    output logic                     debugWirePinOut,
    output logic                     debugWirePinOe,
    // Timer channels on port T
    input  wire logic [T_PINS-1:0]   timerChannelEn,
    input  wire logic [T_PINS-1:0]   timerChannelOut,
    input  wire logic [T_PINS-1:0]   timerChannelOe,
    // Routed serial interface zero on port T bits 1..0
    input  wire logic                serialZeroRouteEn,
    input  wire logic [1:0]          serialZeroOut,
    input  wire logic [1:0]          serialZeroOe,
    // Phy driver output routing
    input  wire logic                phyRouteToPortT,
    input  wire logic                phyRouteToPortS,
    input  wire logic                phyDriverOut,
    // Serial interface on port S bits 1..0
    input  wire logic                serialEn,
    input  wire logic [1:0]          serialOut,
    input  wire logic [1:0]          serialOe,
    // Functions sharing port S bit 2
    input  wire logic                periodicClockOutEn,
    input  wire logic                periodicClockOut,
    input  wire logic                spiEn,
    input  wire logic                spiOut,
    input  wire logic                spiOe,
    input  wire logic                serialOneRouteEn,
    input  wire logic                pwmRouteToPortS,
    input  wire logic                pwmRoutedOut,
    // PWM channels on port P
    input  wire logic [P_PINS-1:0]   pwmChannelEn,
    input  wire logic [P_PINS-1:0]   pwmChannelOut,
    // Debug module drive of the debug wire
    input  wire logic                debugDriveOut,
    input  wire logic                debugDriveOe,
    // Synchronised pin levels and interrupt requests
    output logic      [SYNC_W-1:0]   pinLevels,
    output logic                     bootModeSelect,
    output logic                     externalIntReq,
    output logic                     portPWakeIntReq,
    output logic                     portLWakeIntReq
);

    typedef struct packed {
        logic [T_PINS-1:0] tData;
        logic [T_PINS-1:0] tDir;
        logic [S_PINS-1:0] sData;
        logic [S_PINS-1:0] sDir;
        logic [P_PINS-1:0] pData;
        logic [P_PINS-1:0] pDir;
        logic [P_PINS-1:0] pIntEn;
        logic [P_PINS-1:0] pPol;
        logic [P_PINS-1:0] pFlag;
        logic [L_PINS-1:0] lIntEn;
        logic [L_PINS-1:0] lPol;
        logic [L_PINS-1:0] lFlag;
        logic              irqEn;
        logic              irqEdge;
        logic              irqFlag;
        logic [SYNC_W-1:0] prevSync;
        logic              bootMode;
        logic [31:0]       rdata;
        logic              ready;
        logic              slvErr;
        logic [T_PINS-1:0] tOut;
        logic [T_PINS-1:0] tOe;
        logic [S_PINS-1:0] sOut;
        logic [S_PINS-1:0] sOe;
        logic [P_PINS-1:0] pOut;
        logic [P_PINS-1:0] pOe;
        logic              dbgOut;
        logic              dbgOe;
        logic              irqReq;
        logic              pWakeReq;
        logic              lWakeReq;
    } state_s;

    state_s s_q;
    state_s s_d;
    state_s rstVal;

    logic [SYNC_W-1:0] syncLevel;
    logic [T_PINS-1:0] tLevel;
    logic [S_PINS-1:0] sLevel;
    logic [P_PINS-1:0] pLevel;
    logic [L_PINS-1:0] lLevel;
    logic              dbgLevel;
    logic [9:0]        regIdx;
    logic              setupPhase;
    logic              writeDone;
    logic [7:0]        wByte;
    logic [7:0]        rdByte;
    logic              addrHit;
    logic [P_PINS-1:0] pRise;
    logic [P_PINS-1:0] pFall;
    logic [L_PINS-1:0] lRise;
    logic [L_PINS-1:0] lFall;
    logic [P_PINS-1:0] pEvent;
    logic [L_PINS-1:0] lEvent;
    logic [P_PINS-1:0] pClear;
    logic [L_PINS-1:0] lClear;
    logic              irqFall;
    logic              irqClear;

    // Every pin level is synchronised before any logic looks at it
    pin_sync #(
        .WIDTH (SYNC_W)
    ) u_pin_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .asyncIn  ({debugWirePinIn, portLIn, portPIn, portSIn, portTIn}),
        .syncOut  (syncLevel)
    );

    // Split synchronised levels per port
    assign tLevel   = syncLevel[SYNC_T_LSB +: T_PINS];
    assign sLevel   = syncLevel[SYNC_S_LSB +: S_PINS];
    assign pLevel   = syncLevel[SYNC_P_LSB +: P_PINS];
    assign lLevel   = syncLevel[SYNC_L_LSB +: L_PINS];
    assign dbgLevel = syncLevel[SYNC_DBG_BIT];

    // Bus decode; only the low byte lane carries register data
    assign regIdx     = paddr[11:2];
    assign setupPhase = psel & ~penable;
    assign writeDone  = psel & penable & s_q.ready & pwrite & pstrb[0];
    assign wByte      = pwdata[7:0];

    // Edge detection on synchronised levels against the previous sample
    assign pRise   = pLevel & ~s_q.prevSync[SYNC_P_LSB +: P_PINS];
    assign pFall   = ~pLevel & s_q.prevSync[SYNC_P_LSB +: P_PINS];
    assign lRise   = lLevel & ~s_q.prevSync[SYNC_L_LSB +: L_PINS];
    assign lFall   = ~lLevel & s_q.prevSync[SYNC_L_LSB +: L_PINS];
    assign pEvent  = (s_q.pPol & pRise) | (~s_q.pPol & pFall);
    assign lEvent  = (s_q.lPol & lRise) | (~s_q.lPol & lFall);
    assign irqFall = pFall[PP_IRQ_BIT];

    // Write-one-to-clear strobes for the flag registers
    assign pClear   = (writeDone && regIdx == IDX_P_FLAG) ? wByte[P_PINS-1:0] : '0;
    assign lClear   = (writeDone && regIdx == IDX_L_FLAG) ? wByte[L_PINS-1:0] : '0;
    assign irqClear = writeDone && regIdx == IDX_IRQ_CTRL && wByte[IRQ_FLAG_BIT];

    // Read mux; unmapped indices answer with an error and zero data
    always_comb begin
        rdByte  = 8'h00;
        addrHit = 1'b1;
        unique case (regIdx)
            IDX_T_DATA:   rdByte[T_PINS-1:0] = (s_q.tDir & s_q.tData) | (~s_q.tDir & tLevel);
            IDX_T_INPUT:  rdByte[T_PINS-1:0] = tLevel;
            IDX_T_DIR:    rdByte[T_PINS-1:0] = s_q.tDir;
            IDX_S_DATA:   rdByte[S_PINS-1:0] = (s_q.sDir & s_q.sData) | (~s_q.sDir & sLevel);
            IDX_S_DIR:    rdByte[S_PINS-1:0] = s_q.sDir;
            IDX_P_DATA:   rdByte[P_PINS-1:0] = (s_q.pDir & s_q.pData) | (~s_q.pDir & pLevel);
            IDX_P_DIR:    rdByte[P_PINS-1:0] = s_q.pDir;
            IDX_P_IE:     rdByte[P_PINS-1:0] = s_q.pIntEn;
            IDX_P_POL:    rdByte[P_PINS-1:0] = s_q.pPol;
            IDX_P_FLAG:   rdByte[P_PINS-1:0] = s_q.pFlag;
            IDX_L_INPUT:  rdByte[L_PINS-1:0] = lLevel;
            IDX_L_IE:     rdByte[L_PINS-1:0] = s_q.lIntEn;
            IDX_L_POL:    rdByte[L_PINS-1:0] = s_q.lPol;
            IDX_L_FLAG:   rdByte[L_PINS-1:0] = s_q.lFlag;
            IDX_IRQ_CTRL: begin
                rdByte[IRQ_EN_BIT]   = s_q.irqEn;
                rdByte[IRQ_EDGE_BIT] = s_q.irqEdge;
                rdByte[IRQ_FLAG_BIT] = s_q.irqFlag;
            end
            default:      addrHit = 1'b0;
        endcase
    end

    // Reset image; mode select pin is caught while reset is held
    always_comb begin
        rstVal          = '0;
        rstVal.tData    = REG_RST[T_PINS-1:0];
        rstVal.tDir     = REG_RST[T_PINS-1:0];
        rstVal.sData    = REG_RST[S_PINS-1:0];
        rstVal.sDir     = REG_RST[S_PINS-1:0];
        rstVal.pData    = REG_RST[P_PINS-1:0];
        rstVal.pDir     = REG_RST[P_PINS-1:0];
        rstVal.bootMode = dbgLevel;
        rstVal.prevSync = syncLevel; // No false edge after reset
    end

    // Next state: bus, registers, flags, then pin ownership
    always_comb begin
        s_d          = s_q;
        s_d.prevSync = syncLevel;

        // Answer one cycle after setup so data and ready come from flops
        s_d.ready  = setupPhase;
        s_d.slvErr = setupPhase & ~addrHit;
        s_d.rdata  = setupPhase ? {24'h000000, rdByte} : 32'h00000000;

        // Register writes; input-only registers ignore writes
        if (writeDone) begin
            unique case (regIdx)
                IDX_T_DATA:   s_d.tData  = wByte[T_PINS-1:0];
                IDX_T_DIR:    s_d.tDir   = wByte[T_PINS-1:0];
                IDX_S_DATA:   s_d.sData  = wByte[S_PINS-1:0];
                IDX_S_DIR:    s_d.sDir   = wByte[S_PINS-1:0];
                IDX_P_DATA:   s_d.pData  = wByte[P_PINS-1:0];
                IDX_P_DIR:    s_d.pDir   = wByte[P_PINS-1:0];
                IDX_P_IE:     s_d.pIntEn = wByte[P_PINS-1:0];
                IDX_P_POL:    s_d.pPol   = wByte[P_PINS-1:0];
                IDX_L_IE:     s_d.lIntEn = wByte[L_PINS-1:0];
                IDX_L_POL:    s_d.lPol   = wByte[L_PINS-1:0];
                IDX_IRQ_CTRL: begin
                    s_d.irqEn   = wByte[IRQ_EN_BIT];
                    s_d.irqEdge = wByte[IRQ_EDGE_BIT];
                end
                default:      s_d.tData = s_q.tData;
            endcase
        end

        // Sticky flags; a new event beats a clear in the same cycle
        s_d.pFlag   = (s_q.pFlag & ~pClear) | pEvent;
        s_d.lFlag   = (s_q.lFlag & ~lClear) | lEvent;
        s_d.irqFlag = (s_q.irqFlag & ~irqClear) | irqFall;

        // Request lines
        s_d.pWakeReq = |(s_q.pFlag & s_q.pIntEn);
        s_d.lWakeReq = |(s_q.lFlag & s_q.lIntEn);
        s_d.irqReq   = s_q.irqEn & (s_q.irqEdge ? s_q.irqFlag : ~pLevel[PP_IRQ_BIT]);

        // Port T: GPIO at the bottom, timer above it
        s_d.tOut = (timerChannelEn & timerChannelOut) | (~timerChannelEn & s_q.tData);
        s_d.tOe  = (timerChannelEn & timerChannelOe) | (~timerChannelEn & s_q.tDir);
        if (serialZeroRouteEn) begin
            s_d.tOut[PT_SCI_RX_BIT] = serialZeroOut[0];
            s_d.tOe[PT_SCI_RX_BIT]  = serialZeroOe[0];
        end
        if (serialZeroRouteEn) begin
            s_d.tOut[PT_SHARED_BIT] = serialZeroOut[1];
            s_d.tOe[PT_SHARED_BIT]  = serialZeroOe[1];
        end else if (phyRouteToPortT) begin
            s_d.tOut[PT_SHARED_BIT] = phyDriverOut;
            s_d.tOe[PT_SHARED_BIT]  = 1'b1;
        end

        // Port S: direction bit decides unless a function forces it
        s_d.sOut = s_q.sData;
        s_d.sOe  = s_q.sDir;
        if (serialEn) begin
            s_d.sOut[PS_SCI_RX_BIT] = serialOut[0];
            s_d.sOe[PS_SCI_RX_BIT]  = serialOe[0];
            s_d.sOut[PS_SCI_TX_BIT] = serialOut[1];
            s_d.sOe[PS_SCI_TX_BIT]  = serialOe[1];
        end else if (phyRouteToPortS) begin
            s_d.sOut[PS_PHY_BIT] = phyDriverOut;
            s_d.sOe[PS_PHY_BIT]  = 1'b1;
        end

        // Port S bit 2 in listed order; conversion trigger has no say
        if (periodicClockOutEn) begin
            s_d.sOut[PS_SHARED_BIT] = periodicClockOut;
            s_d.sOe[PS_SHARED_BIT]  = 1'b1;
        end else if (spiEn) begin
            s_d.sOut[PS_SHARED_BIT] = spiOut;
            s_d.sOe[PS_SHARED_BIT]  = spiOe;
        end else if (serialOneRouteEn) begin
            s_d.sOe[PS_SHARED_BIT] = 1'b0;
        end else if (pwmRouteToPortS) begin
            s_d.sOut[PS_SHARED_BIT] = pwmRoutedOut;
            s_d.sOe[PS_SHARED_BIT]  = 1'b1;
        end

        // Port P: PWM above GPIO; interrupt inputs never drive
        s_d.pOut = (pwmChannelEn & pwmChannelOut) | (~pwmChannelEn & s_q.pData);
        s_d.pOe  = pwmChannelEn | s_q.pDir;

        // Debug wire belongs to the debug module once out of reset
        s_d.dbgOut = debugDriveOut;
        s_d.dbgOe  = debugDriveOe;
    end

    // Synchronous reset; forced directions never touch stored bits
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_q <= rstVal;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign prdata          = s_q.rdata;
    assign pready          = s_q.ready;
    assign pslverr         = s_q.slvErr;
    assign portTOut        = s_q.tOut;
    assign portTOe         = s_q.tOe;
    assign portSOut        = s_q.sOut;
    assign portSOe         = s_q.sOe;
    assign portPOut        = s_q.pOut;
    assign portPOe         = s_q.pOe;
    assign debugWirePinOut = s_q.dbgOut;
    assign debugWirePinOe  = s_q.dbgOe;
    assign pinLevels       = s_q.prevSync;
    assign bootModeSelect  = s_q.bootMode;
    assign externalIntReq  = s_q.irqReq;
    assign portPWakeIntReq = s_q.pWakeReq;
    assign portLWakeIntReq = s_q.lWakeReq;

endmodule

// ---- verif/port_mux_sva.sv ----
// Checker: pin ownership and bus timing of the port block
`timescale 1ns/1ns
module port_mux_sva
    import port_pkg::*;
(
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              sys_rst,
    // Bus
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    // Port T
    input wire logic [T_PINS-1:0] portTOut,
    input wire logic [T_PINS-1:0] portTOe,
    input wire logic [T_PINS-1:0] timerChannelEn,
    input wire logic [T_PINS-1:0] timerChannelOut,
    input wire logic [T_PINS-1:0] timerChannelOe,
    input wire logic              serialZeroRouteEn,
    input wire logic [1:0]        serialZeroOut,
    input wire logic [1:0]        serialZeroOe,
    input wire logic              phyRouteToPortT,
    input wire logic              phyDriverOut,
    // Port S bit 2
    input wire logic [S_PINS-1:0] portSOut,
    input wire logic [S_PINS-1:0] portSOe,
    input wire logic              periodicClockOutEn,
    input wire logic              periodicClockOut,
    input wire logic              spiEn,
    input wire logic              spiOe,
    input wire logic              serialOneRouteEn,
    input wire logic              pwmRouteToPortS,
    // Port L levels
    input wire logic [L_PINS-1:0] portLIn,
    input wire logic [SYNC_W-1:0] pinLevels
);
    // One clock domain, so clocking and disable are shared
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_setup; psel && !penable; endsequence
    sequence s_answer; pready ##1 !pready; endsequence
    // Bus answers in the first access cycle, for one cycle only
    property p_apb; s_setup |=> s_answer; endproperty
    a_apb: assert property (p_apb) else $error("bus answer late or long");
    property p_pt0; serialZeroRouteEn && serialZeroOe[0] |=> portTOe[0]
        && portTOut[0] == $past(serialZeroOut[0]); endproperty
    a_pt0: assert property (p_pt0) else $error("T0 not owned by serial zero");
    property p_pt1; phyRouteToPortT && !serialZeroRouteEn |=> portTOe[1]
        && portTOut[1] == $past(phyDriverOut); endproperty
    a_pt1: assert property (p_pt1) else $error("T1 not owned by phy");
    property p_tim; timerChannelEn[3] && timerChannelOe[3] |=> portTOe[3]
        && portTOut[3] == $past(timerChannelOut[3]); endproperty
    a_tim: assert property (p_tim) else $error("T3 not owned by timer");
    property p_clk; periodicClockOutEn |=> portSOe[2]
        && portSOut[2] == $past(periodicClockOut); endproperty
    a_clk: assert property (p_clk) else $error("S2 clock out lost");
    property p_spi; spiEn && !periodicClockOutEn |=> portSOe[2] == $past(spiOe); endproperty
    a_spi: assert property (p_spi) else $error("S2 spi direction wrong");
    property p_one; serialOneRouteEn && !spiEn && !periodicClockOutEn |=> !portSOe[2];
    endproperty
    a_one: assert property (p_one) else $error("S2 serial one not input");
    property p_pwm; pwmRouteToPortS && !serialOneRouteEn && !spiEn && !periodicClockOutEn
        |=> portSOe[2]; endproperty
    a_pwm: assert property (p_pwm) else $error("S2 pwm not output");
    // Level seen three edges after the pin, once reset has been low for the three past cycles
    property p_sync; !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
        |-> pinLevels[SYNC_L_LSB +: L_PINS] == $past(portLIn, 3); endproperty
    a_sync: assert property (p_sync) else $error("L level latency wrong");
endmodule

bind port_pin_mux_and_gpio port_mux_sva chk (.*);

// ---- verif/pin_world.sv ----
// Far side model: package pins of ports T and S with outside drivers
`timescale 1ns/1ns
module pin_world
    import port_pkg::*;
(
    // Device drive
    input  wire logic [T_PINS-1:0] portTOut,
    input  wire logic [T_PINS-1:0] portTOe,
    input  wire logic [S_PINS-1:0] portSOut,
    input  wire logic [S_PINS-1:0] portSOe,
    // Outside drive where the device lets go
    input  wire logic [T_PINS-1:0] extT,
    input  wire logic [S_PINS-1:0] extS,
    // Resolved wire levels
    output logic      [T_PINS-1:0] portTIn,
    output logic      [S_PINS-1:0] portSIn
);
    // Device drive wins; no contention modelled, outside side yields
    assign portTIn = (portTOe & portTOut) | (~portTOe & extT);
    assign portSIn = (portSOe & portSOut) | (~portSOe & extS);
endmodule

// ---- verif/tb_port_pin_mux_and_gpio.sv ----
// Testbench: register access, pin ownership and pin events of the port block
`timescale 1ns/1ns
module tb_port_pin_mux_and_gpio
    import port_pkg::*;
;
    logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [T_PINS-1:0] portTIn, portTOut, portTOe, timerChannelEn, timerChannelOut;
    logic [T_PINS-1:0] timerChannelOe, extT, portLIn;
    logic [S_PINS-1:0] portSIn, portSOut, portSOe, extS;
    logic [P_PINS-1:0] portPIn, portPOut, portPOe, pwmChannelEn, pwmChannelOut;
    logic [1:0] serialZeroOut, serialZeroOe, serialOut, serialOe;
    logic debugWirePinIn, debugWirePinOut, debugWirePinOe, serialZeroRouteEn;
    logic phyRouteToPortT, phyRouteToPortS, phyDriverOut, serialEn, periodicClockOutEn;
    logic periodicClockOut, spiEn, spiOut, spiOe, serialOneRouteEn, pwmRouteToPortS;
    logic pwmRoutedOut, debugDriveOut, debugDriveOe, bootModeSelect, externalIntReq;
    logic portPWakeIntReq, portLWakeIntReq;
    logic [SYNC_W-1:0] pinLevels;
    logic [7:0] rdv;
    logic rde;
    int err_count = 0;
    int n_tests = 0;

    port_pin_mux_and_gpio uut (.*);
    pin_world pins (.*);

    task close_out;
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // One bus transfer; request held until pready is sampled high
    task apb(input bit w, input logic [9:0] ix, input logic [7:0] wd);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdv = prdata[7:0];
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            err_count++;
            close_out();
        end
    endtask
    task rd(input logic [9:0] ix, input logic [7:0] exp);
        apb(1'b0, ix, 8'h00);
        chk(rdv, exp);
    endtask

    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        close_out();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, timerChannelEn, timerChannelOut} = '0;
        {timerChannelOe, extT, extS, pwmChannelEn, pwmChannelOut, serialZeroOut} = '0;
        {serialZeroOe, serialOut, serialOe, serialZeroRouteEn, phyRouteToPortT} = '0;
        {phyRouteToPortS, phyDriverOut, serialEn, periodicClockOutEn, spiEn, spiOut} = '0;
        {periodicClockOut, spiOe, serialOneRouteEn, pwmRouteToPortS, pwmRoutedOut} = '0;
        {debugDriveOut, debugDriveOe} = '0;
        sys_rst = 1'b1;
        pstrb = 4'hF;
        portPIn = 6'h3F;
        portLIn = 4'hA;
        debugWirePinIn = 1'b1;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        cyc(4);
        chk(bootModeSelect, 1'b1);
        rd(IDX_T_DIR, 8'h00);
        rd(IDX_S_DIR, 8'h00);
        rd(IDX_L_INPUT, 8'h0A);
        apb(1'b0, 10'h3FF, 8'h00);
        chk({rde, rdv}, 9'h100);
        $display("test reset and map done");
        apb(1'b1, IDX_T_DIR, 8'h0F);
        apb(1'b1, IDX_T_DATA, 8'h0A);
        cyc(1);
        chk({portTOe, portTOut}, 8'hFA);
        rd(IDX_T_DATA, 8'h0A);
        apb(1'b1, IDX_T_INPUT, 8'hFF);
        rd(IDX_T_INPUT, 8'h0A);
        apb(1'b1, IDX_T_DIR, 8'h00);
        extT <= 4'h5;
        cyc(4);
        rd(IDX_T_DATA, 8'h05);
        rd(IDX_T_INPUT, 8'h05);
        $display("test port T gpio done");
        apb(1'b1, IDX_T_DIR, 8'h0F);
        apb(1'b1, IDX_T_DATA, 8'h00);
        {timerChannelEn, timerChannelOe, timerChannelOut} <= 12'hFF6;
        cyc(2);
        chk(portTOut, 4'h6);
        {serialZeroRouteEn, serialZeroOe, serialZeroOut} <= 5'h1D;
        cyc(2);
        chk(portTOut, 4'h5);
        {serialZeroRouteEn, phyRouteToPortT} <= 2'b01;
        cyc(2);
        chk(portTOut, 4'h4);
        $display("test port T priority done");
        apb(1'b1, IDX_S_DIR, 8'h04);
        apb(1'b1, IDX_S_DATA, 8'h04);
        cyc(1);
        chk({portSOe, portSOut[2]}, 5'h09);
        apb(1'b1, IDX_S_DIR, 8'h00);
        cyc(1);
        chk(portSOe, 4'h0);
        {pwmRouteToPortS, pwmRoutedOut} <= 2'b11;
        cyc(2);
        chk(portSOe[2], 1'b1);
        serialOneRouteEn <= 1'b1;
        cyc(2);
        chk(portSOe[2], 1'b0);
        {spiEn, spiOe} <= 2'b11;
        cyc(2);
        chk({portSOe[2], portSOut[2]}, 2'b10);
        {periodicClockOutEn, periodicClockOut} <= 2'b11;
        cyc(2);
        chk({portSOe[2], portSOut[2]}, 2'b11);
        rd(IDX_S_DIR, 8'h00);
        phyRouteToPortS <= 1'b1;
        cyc(2);
        chk(portSOe[1], 1'b1);
        {serialEn, serialOe} <= 3'b101;
        cyc(2);
        chk(portSOe[1:0], 2'b01);
        $display("test port S ownership done");
        // Falling edge mode, enabled; P bit 0 wake enabled, falling polarity
        apb(1'b1, IDX_IRQ_CTRL, 8'h03);
        apb(1'b1, IDX_P_IE, 8'h01);
        portPIn <= 6'h1E;
        cyc(6);
        chk({externalIntReq, portPWakeIntReq}, 2'b11);
        rd(IDX_P_FLAG, 8'h21);
        portPIn <= 6'h3F;
        apb(1'b1, IDX_P_FLAG, 8'h21);
        apb(1'b1, IDX_IRQ_CTRL, 8'h06);
        portPIn <= 6'h1F;
        cyc(6);
        chk({externalIntReq, portPWakeIntReq}, 2'b00);
        $display("test pin events done");
        {debugDriveOe, debugDriveOut, debugWirePinIn} <= 3'b110;
        cyc(4);
        chk({debugWirePinOe, bootModeSelect}, 2'b11);
        $display("test debug pin done");
        close_out();
    end
endmodule
